// ### pmc_ctrl.sv
// cpu power-mode controller: doze, idle and sleep sequencing
//
// Behaviour
// - slow_run_enable: cpu runs one cycle then idles N-1 cycles.
// - peripheral clock enable stays on every cycle during doze.
// - irq with wake_full_speed_on_irq clear keeps doze rate.
// - irq with wake_full_speed_on_irq set clears slow_run_enable.
// - irq return with slow_on_irq_return set sets slow_run_enable.
// - sleep instruction enters idle if halt_cpu_only_select else sleep.
// - idle stops cpu and memory but keeps peripheral clocks.
// - any interrupt ends idle; halt_cpu_only_select unchanged.
// - irq wake from idle with recovery restores full speed.
// - watchdog wakes idle without reset; slow_run_enable untouched.
// - sleep entry clears watchdog count; watchdog runs in sleep only with i_wdt_sleep_enable.
// - sleep entry clears powerdown_flag and sets timeout_flag.
// - full sleep gates cpu and system clocks.
// - oscillators run in sleep if requested or forced on.
// - sleep entry aborts conversion unless rc clocked; converter_on kept.
// - pins hold pre-sleep drive when no attached peripheral active.
// - pin, brownout or power-on reset resets; others continue.
// - any wake from sleep clears watchdog count.
// - pending enabled irq makes sleep instruction a no-op.
// - irq during sleep entry: finish entry, then wake at once.
// - irq wake vectors to 0004h if global enable, else in-line.
// - crystal wake waits 1024 oscillator periods.
// - low-power regulator in sleep adds settle delay on wake.
// - ratio code 001..111 gives 1:4 .. 1:256, doubling.
// - debugger session forces full speed, register unchanged.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ns
module pmc_ctrl #(
   parameter int PIN_COUNT  = 8,
   parameter int OSC_DIV    = 4,
   parameter int OST_CYCLES = pmc_pkg::OSC_START_PERIODS * OSC_DIV
) (
   input  wire logic                  i_clk,
   input  wire logic                  i_rst,
   input  wire pmc_pkg::pmc_bus_t     i_bus,
   output logic [7:0]                 o_rdata,
   input  wire pmc_pkg::pmc_cpu_ev_t  i_cpu,
   input  wire logic                  i_global_irq_enable,
   input  wire logic                  i_wdt_timeout,
   input  wire logic                  i_wdt_sleep_enable,
   input  wire logic                  i_debugger_session,
   input  wire logic                  i_crystal_mode,
   input  wire logic                  i_converter_rc_osc,
   input  wire logic                  i_converter_busy,
   input  wire pmc_pkg::pmc_osc_t     i_osc_req,
   input  wire logic [PIN_COUNT-1:0]  i_pin_out,
   input  wire logic [PIN_COUNT-1:0]  i_pin_oe,
   input  wire logic [PIN_COUNT-1:0]  i_pin_periph_active,
   output logic                       o_cpu_clk_en,
   output logic                       o_periph_clk_en,
   output logic                       o_sys_clk_en,
   output logic                       o_wdt_clear,
   output logic                       o_wdt_run,
   output logic                       o_wdt_reset_block,
   output logic                       o_converter_abort,
   output pmc_pkg::pmc_osc_t          o_osc_en,
   output logic                       o_reg_lowpower,
   output logic                       o_vector_jump,
   output logic [15:0]                o_vector_addr,
   output logic [PIN_COUNT-1:0]       o_pin_hold,
   output logic [PIN_COUNT-1:0]       o_pin_hold_out,
   output logic [PIN_COUNT-1:0]       o_pin_hold_oe,
   output logic                       o_in_idle,
   output logic                       o_in_sleep
);

   localparam int WCW = $clog2(OST_CYCLES + pmc_pkg::REG_SETTLE_CYC + 2);

   pmc_pkg::pmc_state_t state;
   pmc_pkg::pmc_state_t next_state;

   logic [7:0]      doze_ctrl;
   logic            reg_lowpower;
   logic            timeout_flag;
   logic            powerdown_flag;
   logic [2:0]      osc_force;
   logic [7:0]      doze_cnt;
   logic [WCW-1:0]  wake_cnt;
   logic            wake_by_irq;

   // ratio decode: code n gives a period of 2^(n+1) cycles
   function automatic logic [7:0] ratio_last(input logic [2:0] code);
      logic [8:0] n;
      n = 9'h002 << code;
      ratio_last = 8'(n - 9'h001);
   endfunction

   wire logic [2:0] ratio_code    = doze_ctrl[2:0];
   wire logic [7:0] ratio_max     = ratio_last(ratio_code);
   wire logic       slow_run      = doze_ctrl[pmc_pkg::BIT_SLOW_RUN];
   wire logic       wake_full     = doze_ctrl[pmc_pkg::BIT_WAKE_FULL];
   wire logic       slow_on_ret   = doze_ctrl[pmc_pkg::BIT_SLOW_ON_RET];
   wire logic       halt_only     = doze_ctrl[pmc_pkg::BIT_HALT_CPU_ONLY];
   wire logic       in_run        = (state == pmc_pkg::PMC_RUN);
   wire logic       in_idle       = (state == pmc_pkg::PMC_IDLE);
   wire logic       in_sleep      = (state == pmc_pkg::PMC_SLEEP);
   wire logic       in_wake       = (state == pmc_pkg::PMC_WAKE);

   // pending enabled irq turns sleep into a no-op
   wire logic sleep_go   = in_run && i_cpu.sleep_instr && !i_cpu.irq_pending;
   wire logic enter_sleep = sleep_go && !halt_only;
   wire logic enter_idle  = sleep_go && halt_only;
   // any irq ends idle, global enable ignored
   wire logic idle_irq_wake = in_idle && i_cpu.irq_pending;
   // watchdog wake from idle, not an interrupt
   wire logic idle_wdt_wake = in_idle && i_wdt_timeout && !i_cpu.irq_pending;
   // pending irq wakes sleep at once; watchdog continues too
   wire logic sleep_wake = in_sleep && (i_cpu.irq_pending || i_wdt_timeout);

   // only with recovery set does an irq clear doze
   wire logic hw_clr_slow = wake_full &&
                            ((in_run && i_cpu.irq_entry) || idle_irq_wake ||
                             (in_wake && wake_by_irq &&
                              next_state == pmc_pkg::PMC_RUN));
   wire logic hw_set_slow = slow_on_ret && in_run && i_cpu.irq_return;

   wire logic wr_doze = i_bus.wr && i_bus.addr == pmc_pkg::ADDR_DOZE_CTRL;
   wire logic wr_reg  = i_bus.wr && i_bus.addr == pmc_pkg::ADDR_REG_CTRL;
   wire logic wr_osc  = i_bus.wr && i_bus.addr == pmc_pkg::ADDR_OSC_CTRL;

   // hardware update to slow_run_enable wins over a software write
   wire logic next_slow = hw_clr_slow ? 1'b0 :
                          hw_set_slow ? 1'b1 :
                          wr_doze ? i_bus.wdata[pmc_pkg::BIT_SLOW_RUN] :
                          slow_run;
   wire logic [7:0] doze_sw = wr_doze ? (i_bus.wdata & 8'hF7) : doze_ctrl;
   wire logic [7:0] next_doze = {doze_sw[7], next_slow, doze_sw[5:0]};

   // wake delay: oscillator start-up plus regulator settle
   wire logic [WCW-1:0] wake_len =
      (i_crystal_mode ? WCW'(OST_CYCLES) : '0) +
      (reg_lowpower ? WCW'(pmc_pkg::REG_SETTLE_CYC) : '0);

   always_comb begin
      next_state = state;
      unique case (state)
         pmc_pkg::PMC_RUN: begin
            if (enter_sleep)
               next_state = pmc_pkg::PMC_SLEEP;
            else if (enter_idle)
               next_state = pmc_pkg::PMC_IDLE;
         end
         pmc_pkg::PMC_IDLE: begin
            if (idle_irq_wake || idle_wdt_wake)
               next_state = pmc_pkg::PMC_RUN;
         end
         pmc_pkg::PMC_SLEEP: begin
            if (sleep_wake)
               next_state = pmc_pkg::PMC_WAKE;
         end
         pmc_pkg::PMC_WAKE: begin
            if (wake_cnt == '0)
               next_state = pmc_pkg::PMC_RUN;
         end
      endcase
   end

   // doze counter; one active cycle per ratio period
   wire logic doze_tick = (doze_cnt == 8'h00);
   // debugger session forces full speed without touching the bit
   wire logic slow_eff = slow_run && !i_debugger_session;
   wire logic [7:0] next_doze_cnt =
      (!slow_eff || doze_cnt >= ratio_max) ? 8'h00 : doze_cnt + 8'h01;

   // hold a pin only when no attached peripheral is active
   wire logic [PIN_COUNT-1:0] hold_mask = ~i_pin_periph_active;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= pmc_pkg::PMC_RUN;
         doze_ctrl <= pmc_pkg::RST_DOZE_CTRL;
         reg_lowpower <= 1'b0;
         osc_force <= 3'h0;
         doze_cnt <= 8'h00;
         wake_cnt <= '0;
         wake_by_irq <= 1'b0;
      end else begin
         state <= next_state;
         // halt_cpu_only_select is only changed by software
         doze_ctrl <= next_doze;
         if (wr_reg)
            reg_lowpower <= i_bus.wdata[pmc_pkg::BIT_REG_LOWPOWER];
         if (wr_osc)
            osc_force <= i_bus.wdata[2:0];
         doze_cnt <= next_doze_cnt;
         if (sleep_wake) begin
            wake_cnt <= wake_len;
            wake_by_irq <= i_cpu.irq_pending;
         end else if (in_wake && wake_cnt != '0) begin
            wake_cnt <= wake_cnt - WCW'(1);
         end
      end
   end

   // status flags; power-on values set timeout and powerdown flags
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         timeout_flag <= 1'b1;
         powerdown_flag <= 1'b1;
      end else if (enter_sleep) begin
         timeout_flag <= 1'b1;
         powerdown_flag <= 1'b0;
      end
   end

   // registered read data, valid the cycle after the strobe
   logic [7:0] rd_mux;
   always_comb begin
      unique case (i_bus.addr)
         pmc_pkg::ADDR_DOZE_CTRL: rd_mux = doze_ctrl;
         pmc_pkg::ADDR_REG_CTRL:  rd_mux = {6'h00, reg_lowpower, 1'b1};
         pmc_pkg::ADDR_STATUS:
            rd_mux = {3'h0, timeout_flag, powerdown_flag, 3'h0};
         pmc_pkg::ADDR_OSC_CTRL:  rd_mux = {5'h00, osc_force};
         default:                 rd_mux = 8'h00;
      endcase
   end

   wire logic next_run     = (next_state == pmc_pkg::PMC_RUN);
   wire logic next_sleepy  = (next_state == pmc_pkg::PMC_SLEEP) ||
                             (next_state == pmc_pkg::PMC_WAKE);
   wire logic next_dozecnt0 = (next_doze_cnt == 8'h00);
   // vector on irq wake with global enable set
   wire logic wake_done_irq = (in_wake && wake_cnt == '0 && wake_by_irq) ||
                              idle_irq_wake;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
         o_cpu_clk_en <= 1'b1;
         o_periph_clk_en <= 1'b1;
         o_sys_clk_en <= 1'b1;
         o_wdt_clear <= 1'b0;
         o_wdt_run <= 1'b1;
         o_wdt_reset_block <= 1'b0;
         o_converter_abort <= 1'b0;
         o_osc_en <= '0;
         o_reg_lowpower <= 1'b0;
         o_vector_jump <= 1'b0;
         o_vector_addr <= 16'h0000;
         o_pin_hold <= '0;
         o_pin_hold_out <= '0;
         o_pin_hold_oe <= '0;
         o_in_idle <= 1'b0;
         o_in_sleep <= 1'b0;
      end else begin
         o_rdata <= i_bus.rd ? rd_mux : 8'h00;
         // cpu clock only in run, at doze rate
         o_cpu_clk_en <= next_run && (!slow_eff || next_dozecnt0);
         // peripherals keep full rate outside sleep
         o_periph_clk_en <= !next_sleepy;
         // system clock off in full sleep
         o_sys_clk_en <= !next_sleepy;
         // clear count on sleep entry and every wake from sleep
         o_wdt_clear <= enter_sleep || sleep_wake;
         // watchdog runs in sleep only if enabled for it
         o_wdt_run <= !next_sleepy || i_wdt_sleep_enable;
         // watchdog timeout wakes idle instead of resetting
         o_wdt_reset_block <= (next_state == pmc_pkg::PMC_IDLE) ||
                              next_sleepy;
         // abort unless rc clocked; converter_on left to software
         o_converter_abort <= enter_sleep && !i_converter_rc_osc &&
                              i_converter_busy;
         // oscillators in sleep only when requested or forced
         o_osc_en.hf  <= !next_sleepy || i_osc_req.hf ||
                         osc_force[pmc_pkg::BIT_HF_FORCE];
         o_osc_en.lf  <= !next_sleepy || i_osc_req.lf ||
                         osc_force[pmc_pkg::BIT_LF_FORCE];
         o_osc_en.sec <= i_osc_req.sec ||
                         osc_force[pmc_pkg::BIT_SEC_FORCE];
         // regulator low power only while asleep
         o_reg_lowpower <= reg_lowpower && (next_state == pmc_pkg::PMC_SLEEP);
         // vector or fall through to the next instruction
         o_vector_jump <= wake_done_irq && i_global_irq_enable;
         o_vector_addr <= pmc_pkg::IRQ_VECTOR;
         // latch pin drive at entry, release on wake
         if (enter_sleep) begin
            o_pin_hold_out <= i_pin_out;
            o_pin_hold_oe <= i_pin_oe;
         end
         o_pin_hold <= next_sleepy ? hold_mask : '0;
         o_in_idle <= (next_state == pmc_pkg::PMC_IDLE);
         o_in_sleep <= next_sleepy;
      end
   end

endmodule // pmc_ctrl

// ### pmc_pkg.sv
// shared constants and types for the cpu power-mode controller
package pmc_pkg;

   // register map of the power-mode controller
   localparam logic [3:0] ADDR_DOZE_CTRL = 4'h0;
   localparam logic [3:0] ADDR_REG_CTRL  = 4'h1;
   localparam logic [3:0] ADDR_STATUS    = 4'h2;
   localparam logic [3:0] ADDR_OSC_CTRL  = 4'h3;

   // doze control field positions
   localparam int BIT_HALT_CPU_ONLY = 7;
   localparam int BIT_SLOW_RUN      = 6;
   localparam int BIT_WAKE_FULL     = 5;
   localparam int BIT_SLOW_ON_RET   = 4;
   // regulator control: bit 1 low-power select, bit 0 reserved reads one
   localparam int BIT_REG_LOWPOWER  = 1;
   localparam int BIT_REG_RESERVED  = 0;
   // status: bit 4 timeout flag, bit 3 powerdown flag
   localparam int BIT_TIMEOUT       = 4;
   localparam int BIT_POWERDOWN     = 3;
   // oscillator force-on bits
   localparam int BIT_HF_FORCE      = 2;
   localparam int BIT_LF_FORCE      = 1;
   localparam int BIT_SEC_FORCE     = 0;

   localparam logic [7:0] RST_DOZE_CTRL = 8'h00;
   localparam logic [7:0] RST_REG_CTRL  = 8'h01;
   localparam logic [7:0] RST_OSC_CTRL  = 8'h00;

   // irq vector address after wake with global enable set
   localparam logic [15:0] IRQ_VECTOR = 16'h0004;

   // oscillator start-up delay in oscillator periods
   localparam int OSC_START_PERIODS = 1024;
   // extra regulator settle time, in ns (plain default)
   localparam int REG_SETTLE_NS     = 1000;
   localparam int CLK_PERIOD_NS     = 10;
   localparam int REG_SETTLE_CYC    =
      (REG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      PMC_RUN,
      PMC_IDLE,
      PMC_SLEEP,
      PMC_WAKE
   } pmc_state_t;

   // register bus request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } pmc_bus_t;

   // events from the cpu core
   typedef struct packed {
      logic sleep_instr;
      logic irq_entry;
      logic irq_return;
      logic irq_pending;
   } pmc_cpu_ev_t;

   // oscillator requests from peripherals
   typedef struct packed {
      logic hf;
      logic lf;
      logic sec;
   } pmc_osc_t;

endpackage

// ### pmc_ctrl_assertions.sv
// concurrent checks on the power-mode controller ports
`timescale 1ns/1ns
module pmc_ctrl_assertions (
   input wire logic                 i_clk,
   input wire logic                 i_rst,
   input wire pmc_pkg::pmc_bus_t    i_bus,
   input wire logic [7:0]           o_rdata,
   input wire pmc_pkg::pmc_cpu_ev_t i_cpu,
   input wire logic                 i_wdt_timeout,
   input wire logic                 i_converter_rc_osc,
   input wire logic                 i_converter_busy,
   input wire pmc_pkg::pmc_osc_t    i_osc_req,
   input wire logic                 o_cpu_clk_en,
   input wire logic                 o_periph_clk_en,
   input wire logic                 o_sys_clk_en,
   input wire logic                 o_wdt_clear,
   input wire logic                 o_wdt_reset_block,
   input wire logic                 o_converter_abort,
   input wire pmc_pkg::pmc_osc_t    o_osc_en,
   input wire logic                 o_vector_jump,
   input wire logic [15:0]          o_vector_addr,
   input wire logic                 o_in_idle,
   input wire logic                 o_in_sleep
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);

   // sleep instruction taken in run state, nothing pending
   sequence s_enter;
      i_cpu.sleep_instr && !i_cpu.irq_pending && !o_in_sleep && !o_in_idle;
   endsequence
   // sleep instruction with an enabled interrupt already pending
   sequence s_noop;
      i_cpu.sleep_instr && i_cpu.irq_pending && !o_in_sleep && !o_in_idle;
   endsequence

   a_entry_wdt_clear: assert property (
      s_enter ##1 o_in_sleep |-> o_wdt_clear)
      else $error("watchdog not cleared on sleep entry");
   a_entry_abort: assert property (
      s_enter ##1 o_in_sleep |-> o_converter_abort ==
         (!$past(i_converter_rc_osc) && $past(i_converter_busy)))
      else $error("converter abort wrong on sleep entry");
   a_pending_noop: assert property (
      s_noop |=> !o_in_sleep && !o_in_idle && !o_wdt_clear)
      else $error("sleep with pending irq was not a no-op");
   a_sleep_gates_clk: assert property (
      o_in_sleep |-> !o_cpu_clk_en && !o_sys_clk_en)
      else $error("clocks running in sleep");
   a_idle_periph_run: assert property (
      o_in_idle |-> o_periph_clk_en && !o_cpu_clk_en)
      else $error("idle clock enables wrong");
   a_idle_exit: assert property (
      o_in_idle && (i_cpu.irq_pending || i_wdt_timeout) |=> !o_in_idle)
      else $error("idle not left after wake event");
   a_wdt_blocked: assert property (
      o_in_idle || o_in_sleep |-> o_wdt_reset_block)
      else $error("watchdog reset not blocked");
   a_sleep_irq_wake: assert property (
      o_in_sleep && i_cpu.irq_pending |-> ##[1:400] !o_in_sleep)
      else $error("no wake from sleep on pending irq");
   a_vector_addr: assert property (
      o_vector_jump |-> o_vector_addr == pmc_pkg::IRQ_VECTOR &&
                        $past(o_in_idle || o_in_sleep))
      else $error("vector address wrong");
   a_rdata_quiet: assert property (
      !i_bus.rd |=> o_rdata == 8'h00)
      else $error("read data outside read answer");
   a_periph_in_run: assert property (
      !o_in_sleep |-> o_periph_clk_en)
      else $error("peripheral clock stopped outside sleep");
   a_osc_request: assert property (
      o_in_sleep && i_osc_req.lf ##1 o_in_sleep |-> o_osc_en.lf)
      else $error("requested oscillator stopped in sleep");
endmodule // pmc_ctrl_assertions

// ### pmc_cpu_model.sv
// behavioural cpu core: instruction events and pending interrupt level
`timescale 1ns/1ns
module pmc_cpu_model (
   input  wire logic            i_clk,
   output pmc_pkg::pmc_cpu_ev_t o_cpu
);
   initial o_cpu = '0;
   // bit 3 sleep, 2 irq entry, 1 irq return: one-cycle pulses
   task automatic pulse(input int kind);
      @(posedge i_clk);
      o_cpu[kind] <= 1'b1;
      @(posedge i_clk);
      o_cpu[kind] <= 1'b0;
   endtask
   task automatic set_pending(input logic v);
      @(posedge i_clk);
      o_cpu.irq_pending <= v;
   endtask
endmodule // pmc_cpu_model

// ### pmc_ctrl_test.sv
// self-checking bench for the power-mode controller
`timescale 1ns/1ns
module pmc_ctrl_test;
   localparam int OST = 8;
   logic                 clk = 1'b0;
   logic                 rst = 1'b1;
   pmc_pkg::pmc_bus_t    bus = '0;
   pmc_pkg::pmc_cpu_ev_t cpu;
   pmc_pkg::pmc_osc_t    osc_req = '0;
   pmc_pkg::pmc_osc_t    osc_en;
   logic                 global_irq_enable = 1'b0, wdt_to = 1'b0, dbg = 1'b0;
   logic                 crystal = 1'b0, rc_osc = 1'b0;
   logic                 wdt_sen = 1'b0, conv_busy = 1'b1;
   logic [7:0]           pin_out = 8'h00, pin_oe = 8'h00, pin_act = 8'h00;
   logic [7:0]           rdata, hold, hold_out, hold_oe;
   logic                 cpu_en, sys_en, wdt_clr, in_idle, in_sleep;
   logic                 periph_en, wdt_run, wdt_blk, conv_abort;
   logic                 vjump, lowp;
   logic [15:0]          vaddr;
   int                   error_cnt = 0, checks_done = 0;
   int                   jmp_cnt = 0, clr_cnt = 0, abt_cnt = 0;
   int                   n, c0, j0, a0;
   logic [7:0]           hw_w [3] = '{8'h47, 8'h67, 8'h17};
   logic [7:0]           hw_e [3] = '{8'h47, 8'h27, 8'h57};
   int                   hw_ev [3] = '{2, 2, 1};

   always #5 clk = ~clk;
   always @(posedge clk) begin
      jmp_cnt <= jmp_cnt + int'(vjump);
      clr_cnt <= clr_cnt + int'(wdt_clr);
      abt_cnt <= abt_cnt + int'(conv_abort);
   end

   pmc_cpu_model i_pmc_cpu_model (.i_clk(clk), .o_cpu(cpu));

   pmc_ctrl #(.OST_CYCLES(OST)) i_pmc_ctrl (
      .i_clk(clk), .i_rst(rst), .i_bus(bus), .o_rdata(rdata), .i_cpu(cpu),
      .i_global_irq_enable(global_irq_enable), .i_wdt_timeout(wdt_to),
      .i_wdt_sleep_enable(wdt_sen), .i_debugger_session(dbg),
      .i_crystal_mode(crystal), .i_converter_rc_osc(rc_osc),
      .i_converter_busy(conv_busy), .i_osc_req(osc_req), .i_pin_out(pin_out),
      .i_pin_oe(pin_oe), .i_pin_periph_active(pin_act),
      .o_cpu_clk_en(cpu_en), .o_periph_clk_en(periph_en),
      .o_sys_clk_en(sys_en), .o_wdt_clear(wdt_clr), .o_wdt_run(wdt_run),
      .o_wdt_reset_block(wdt_blk), .o_converter_abort(conv_abort),
      .o_osc_en(osc_en), .o_reg_lowpower(lowp), .o_vector_jump(vjump),
      .o_vector_addr(vaddr), .o_pin_hold(hold), .o_pin_hold_out(hold_out),
      .o_pin_hold_oe(hold_oe), .o_in_idle(in_idle), .o_in_sleep(in_sleep));

   task automatic end_of_test();
      $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string w, input logic [15:0] e,
                      input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", w, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input string w);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 chk(w, 16'(e), 16'(rdata));
   endtask
   // bounded wait for a level; running out ends the run
   task automatic wait_lvl(ref logic s, input logic v, output int k);
      k = 0;
      while (s !== v && k < 2000) begin
         @(posedge clk);
         #1 k++;
      end
      chk("wait level", 16'(v), 16'(s));
      if (s !== v) begin
         end_of_test();
      end
   endtask
   task automatic period(output int p);
      int k;
      wait_lvl(cpu_en, 1'b0, k);
      wait_lvl(cpu_en, 1'b1, k);
      wait_lvl(cpu_en, 1'b0, p);
      wait_lvl(cpu_en, 1'b1, k);
      p = p + k;
   endtask

   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(pmc_pkg::ADDR_DOZE_CTRL, pmc_pkg::RST_DOZE_CTRL, "doze");
      rd(pmc_pkg::ADDR_REG_CTRL, pmc_pkg::RST_REG_CTRL, "regctl");
      rd(pmc_pkg::ADDR_OSC_CTRL, pmc_pkg::RST_OSC_CTRL, "osc");
      wr(4'hF, 8'hFF);
      rd(4'hF, 8'h00, "unmapped");
      // status is read only: the write must vanish
      wr(pmc_pkg::ADDR_STATUS, 8'h00);
      rd(pmc_pkg::ADDR_STATUS, 8'h18, "status");
      i_pmc_cpu_model.set_pending(1'b1);
      i_pmc_cpu_model.pulse(3);
      i_pmc_cpu_model.set_pending(1'b0);
      #1 chk("noop sleep", 16'h0, 16'(in_sleep | in_idle));
      rd(pmc_pkg::ADDR_STATUS, 8'h18, "status noop");
      $display("registers and no-op sleep done");
      for (int r = 1; r < 8; r++) begin
         wr(pmc_pkg::ADDR_DOZE_CTRL, 8'h48 | 8'(r));
         rd(pmc_pkg::ADDR_DOZE_CTRL, 8'h40 | 8'(r), "doze bit3");
         period(n);
         chk("doze period", 16'(2 ** (r + 1)), 16'(n));
      end
      @(posedge clk);
      dbg <= 1'b1;
      repeat (2) @(posedge clk);
      repeat (4) begin
         @(posedge clk);
         #1 chk("debug cpu_en", 16'h1, 16'(cpu_en));
      end
      @(posedge clk);
      dbg <= 1'b0;
      rd(pmc_pkg::ADDR_DOZE_CTRL, 8'h47, "debug doze");
      for (int t = 0; t < 3; t++) begin
         wr(pmc_pkg::ADDR_DOZE_CTRL, hw_w[t]);
         i_pmc_cpu_model.pulse(hw_ev[t]);
         rd(pmc_pkg::ADDR_DOZE_CTRL, hw_e[t], "doze hw");
      end
      $display("doze done");
      wr(pmc_pkg::ADDR_DOZE_CTRL, 8'hE7);
      i_pmc_cpu_model.pulse(3);
      wait_lvl(in_idle, 1'b1, n);
      chk("idle clocks", 16'h1, 16'(periph_en & !cpu_en & wdt_blk));
      i_pmc_cpu_model.set_pending(1'b1);
      wait_lvl(in_idle, 1'b0, n);
      i_pmc_cpu_model.set_pending(1'b0);
      rd(pmc_pkg::ADDR_DOZE_CTRL, 8'hA7, "idle irq");
      wr(pmc_pkg::ADDR_DOZE_CTRL, 8'hC7);
      i_pmc_cpu_model.pulse(3);
      wait_lvl(in_idle, 1'b1, n);
      @(posedge clk);
      wdt_to <= 1'b1;
      @(posedge clk);
      wdt_to <= 1'b0;
      wait_lvl(in_idle, 1'b0, n);
      rd(pmc_pkg::ADDR_DOZE_CTRL, 8'hC7, "idle wdt");
      $display("idle done");
      wr(pmc_pkg::ADDR_DOZE_CTRL, 8'h00);
      wr(pmc_pkg::ADDR_REG_CTRL, 8'h03);
      wr(pmc_pkg::ADDR_OSC_CTRL, 8'h04);
      @(posedge clk);
      crystal <= 1'b1;
      global_irq_enable <= 1'b1;
      osc_req <= 3'b010;
      pin_out <= 8'hA5;
      pin_oe <= 8'hF0;
      pin_act <= 8'h0F;
      c0 = clr_cnt;
      j0 = jmp_cnt;
      a0 = abt_cnt;
      i_pmc_cpu_model.pulse(3);
      wait_lvl(in_sleep, 1'b1, n);
      repeat (2) @(posedge clk);
      #1 chk("osc_en", 16'h0006, 16'(osc_en));
      chk("pin hold", 16'h00F0, 16'(hold));
      chk("held drive", 16'h00A0, 16'(hold & hold_out));
      chk("lowpower", 16'h1, 16'(lowp));
      chk("sys_en", 16'h0, 16'(sys_en));
      chk("wdt_run", 16'h0, 16'(wdt_run));
      chk("wdt block", 16'h1, 16'(wdt_blk));
      chk("held oe", 16'h00F0, 16'(hold & hold_oe));
      i_pmc_cpu_model.set_pending(1'b1);
      wait_lvl(in_sleep, 1'b0, n);
      chk("wake delay", 16'h1, 16'(n >= OST + pmc_pkg::REG_SETTLE_CYC &&
          n <= OST + pmc_pkg::REG_SETTLE_CYC + 4));
      i_pmc_cpu_model.set_pending(1'b0);
      rd(pmc_pkg::ADDR_STATUS, 8'h10, "status sleep");
      chk("vector", pmc_pkg::IRQ_VECTOR, vaddr);
      chk("jumps", 16'h1, 16'(jmp_cnt - j0 == 1));
      chk("wdt clears", 16'h1, 16'(clr_cnt - c0 == 2));
      chk("aborts", 16'h1, 16'(abt_cnt - a0 == 1));
      wr(pmc_pkg::ADDR_REG_CTRL, 8'h01);
      @(posedge clk);
      global_irq_enable <= 1'b0;
      rc_osc <= 1'b1;
      wdt_sen <= 1'b1;
      j0 = jmp_cnt;
      a0 = abt_cnt;
      i_pmc_cpu_model.pulse(3);
      wait_lvl(in_sleep, 1'b1, n);
      chk("wdt_run sleep", 16'h1, 16'(wdt_run));
      @(posedge clk);
      wdt_to <= 1'b1;
      @(posedge clk);
      wdt_to <= 1'b0;
      wait_lvl(in_sleep, 1'b0, n);
      repeat (4) @(posedge clk);
      #1 chk("in-line wake", 16'h1, 16'(jmp_cnt == j0));
      chk("rc aborts", 16'h1, 16'(abt_cnt == a0));
      $display("sleep done");
      end_of_test();
   end
endmodule // pmc_ctrl_test

bind pmc_ctrl pmc_ctrl_assertions i_pmc_ctrl_assertions (
   .i_clk, .i_rst, .i_bus, .o_rdata, .i_cpu, .i_wdt_timeout,
   .i_converter_rc_osc, .i_converter_busy, .i_osc_req, .o_cpu_clk_en,
   .o_periph_clk_en,
   .o_sys_clk_en, .o_wdt_clear, .o_wdt_reset_block, .o_converter_abort,
   .o_osc_en, .o_vector_jump, .o_vector_addr, .o_in_idle, .o_in_sleep);
